// ===== src/msf_pkg.sv
/*
 * msf_pkg: constants and the state types shared by the motion status flag block.
 * assumes a single 20 MHz control clock and 16-bit register port data.
 */
package msf_pkg;

    // timing: hold time is set in milliseconds
    localparam int unsigned CLK_PERIOD_NS = 50;       // ref_clk period
    localparam int unsigned HOLD_UNIT_NS  = 1000000;  // one millisecond
    localparam int unsigned MS_CYCLES     = HOLD_UNIT_NS / CLK_PERIOD_NS;

    // register indices on the plain register port
    localparam logic [3:0] REG_COND_SEL  = 4'h0;  // positioning_condition_select
    localparam logic [3:0] REG_DONE_THR  = 4'h1;  // positioning complete threshold
    localparam logic [3:0] REG_NEAR_POS  = 4'h2;  // positioning approach threshold
    localparam logic [3:0] REG_HOLD_TIME = 4'h3;  // positioning_flag_hold_time
    localparam logic [3:0] REG_ROT_THR   = 4'h4;  // rotation_detect_speed_threshold
    localparam logic [3:0] REG_MATCH_THR = 4'h5;  // speed_match_threshold
    localparam logic [3:0] REG_NEAR_THR  = 4'h6;  // speed_near_threshold
    localparam logic [3:0] REG_ZERO_THR  = 4'h7;  // standstill_speed_threshold
    localparam logic [3:0] REG_TRQ_THR   = 4'h8;  // torque_reached_threshold
    localparam logic [3:0] REG_TRQ_HYST  = 4'h9;  // torque_reached_hysteresis
    localparam logic [3:0] REG_FLAGS     = 4'ha;  // live flags, read only
    localparam logic [3:0] REG_IRQ_STAT  = 4'hb;  // sticky events, write one to clear
    localparam logic [3:0] REG_IRQ_MASK  = 4'hc;  // interrupt enables

    // reset values
    localparam logic [1:0]  RST_COND_SEL  = 2'h0;
    localparam logic [15:0] RST_DONE_THR  = 16'h0320;
    localparam logic [15:0] RST_NEAR_POS  = 16'h1388;
    localparam logic [15:0] RST_HOLD_TIME = 16'h0064;
    localparam logic [15:0] RST_ROT_THR   = 16'h0014;
    localparam logic [15:0] RST_MATCH_THR = 16'h000a;
    localparam logic [15:0] RST_NEAR_THR  = 16'h0064;
    localparam logic [15:0] RST_ZERO_THR  = 16'h000a;
    localparam logic [15:0] RST_TRQ_THR   = 16'h0064;
    localparam logic [15:0] RST_TRQ_HYST  = 16'h000a;
    localparam logic [6:0]  RST_IRQ_MASK  = 7'h00;

    // positioning condition encodings
    localparam logic [1:0] COND_DEV_ONLY = 2'h0;
    localparam logic [1:0] COND_HOLD     = 2'h3;

    // flag bit positions in flags, status and mask registers
    localparam int FLG_POS_DONE = 0;
    localparam int FLG_POS_NEAR = 1;
    localparam int FLG_ROTATE   = 2;
    localparam int FLG_CONSIST  = 3;
    localparam int FLG_APPROACH = 4;
    localparam int FLG_ZERO     = 5;
    localparam int FLG_TORQUE   = 6;
    localparam int NUM_FLAGS    = 7;

    // whole state of the top module except its two hold timers
    typedef struct packed {
        logic [1:0]           cond_sel;
        logic [15:0]          done_thr;
        logic [15:0]          near_pos;
        logic [15:0]          hold_ms;
        logic [15:0]          rot_thr;
        logic [15:0]          match_thr;
        logic [15:0]          near_thr;
        logic [15:0]          zero_thr;
        logic [15:0]          trq_thr;
        logic [15:0]          trq_hyst;
        logic [NUM_FLAGS-1:0] flags;
        logic [NUM_FLAGS-1:0] irq_stat;
        logic [NUM_FLAGS-1:0] irq_mask;
        logic                 irq;
        logic [15:0]          rdata;
    } msf_state_t;

    // whole state of one hold timer
    typedef struct packed {
        logic [15:0] ms_left;
        logic [15:0] pre;
    } msf_hold_state_t;

endpackage : msf_pkg

// ===== src/msf_hold_if.sv
/*
 * msf_hold_if: ties one positioning condition to its hold timer.
 * assumes both ends run on ref_clk.
 */
interface msf_hold_if;
    logic        cond;     // raw positioning condition, level
    logic [15:0] hold_ms;  // hold time in milliseconds
    logic        held;     // condition stretched by the hold time

    modport ctl (output cond, output hold_ms, input held);
    modport tmr (input cond, input hold_ms, output held);
endinterface : msf_hold_if

// ===== src/msf_hold_timer.sv
/*
 * msf_hold_timer: keeps a condition asserted for hold_ms milliseconds after it falls.
 * assumes cond is produced on ref_clk; the millisecond is an enable from a prescaler.
 */
module msf_hold_timer
    import msf_pkg::*;
#(
    parameter int unsigned MS_LEN = MS_CYCLES  // cycles per millisecond
) (
    input  wire logic ref_clk,
    input  wire logic rst,
    msf_hold_if.tmr   hif
);

    localparam logic [15:0] PRE_LAST = 16'(MS_LEN - 1);  // last prescaler count

    msf_hold_state_t st;       // registered state
    msf_hold_state_t next_st;  // next state

    // held is the live condition or a running countdown
    assign hif.held = hif.cond | (st.ms_left != 16'h0000);

    // prescaler restarts while cond is high so the hold is exact, not +-1 ms
    always_comb begin
        next_st = st;
        if (hif.cond) begin
            next_st.ms_left = hif.hold_ms;
            next_st.pre     = 16'h0000;
        end else if (st.ms_left != 16'h0000) begin
            if (st.pre == PRE_LAST) begin
                next_st.pre     = 16'h0000;
                next_st.ms_left = st.ms_left - 16'h0001;  // one ms elapsed
            end else begin
                next_st.pre = st.pre + 16'h0001;
            end
        end
    end

    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // a falling condition with a non-zero hold stays visible
    chk_hold_after_fall: assert property (@(posedge ref_clk) disable iff (rst)
        ($fell(hif.cond) && $past(hif.hold_ms) != 16'h0000) |-> hif.held [*2])
        else $error("hold timer dropped the flag right after the condition fell");

endmodule : msf_hold_timer

// ===== src/msf_flags.sv
/*
 * msf_flags: speed, torque and positioning status flags of the drive, with
 * thresholds, flag readback and a masked interrupt on a plain register port.
 * assumes speed, torque and deviation samples come from logic on ref_clk, so
 * they are read without synchronisers.
 */
// Behaviour
// - position mode: flags when deviation within threshold
// - condition 3: positioning flags held for time
// - rotating flag when speed reaches rotation threshold
// - consistent flag when speed matches instruction
// - approach flag when speed reaches approach threshold
// - zero-speed flag when speed below threshold
module msf_flags
    import msf_pkg::*;
#(
    parameter int unsigned MS_LEN = MS_CYCLES  // cycles per millisecond
) (
    input  wire logic               ref_clk,
    input  wire logic               rst,
    input  wire logic [3:0]         reg_addr,
    input  wire logic [15:0]        reg_wdata,
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    output logic      [15:0]        reg_rdata,
    input  wire logic signed [15:0] speed_actual,
    input  wire logic signed [15:0] speed_instr,
    input  wire logic signed [15:0] torque_actual,
    input  wire logic               position_mode,
    input  wire logic signed [31:0] pos_deviation,
    input  wire logic               pos_instr_idle,
    input  wire logic               pos_continuous_ok,
    output logic                    positioning_complete_flag,
    output logic                    positioning_approach_flag,
    output logic                    motor_rotating_flag,
    output logic                    speed_consistent_flag,
    output logic                    speed_approach_flag,
    output logic                    zero_speed_flag,
    output logic                    torque_arrived_flag,
    output logic                    irq
);

    // magnitude of a signed value; the most negative input saturates
    function automatic logic [31:0] msf_abs(input logic signed [31:0] v);
        logic [31:0] r;
        r = v[31] ? 32'(-v) : 32'(v);
        if (r[31]) begin
            r = 32'h7fffffff;
        end
        return r;
    endfunction : msf_abs

    msf_state_t st;       // registered state
    msf_state_t next_st;  // next state

    logic [31:0] spd_abs;     // |actual speed|
    logic [31:0] err_abs;     // |actual - instructed speed|
    logic [31:0] trq_abs;     // |torque|
    logic [31:0] dev_abs;     // |position deviation|
    logic [15:0] trq_low;     // torque release level
    logic        cond_ok;     // positioning gating per condition select
    logic        done_raw;    // deviation inside completion threshold
    logic        near_raw;    // deviation inside approach threshold
    logic        done_sel;    // completion flag after optional hold
    logic        near_sel;    // approach flag after optional hold
    logic        hit_sel;     // register port address decode result
    logic        use_hold;    // condition select asks for the hold time

    msf_hold_if hold_done ();  // completion hold channel
    msf_hold_if hold_near ();  // approach hold channel

    // measured magnitudes, widened so the difference cannot overflow
    always_comb begin
        spd_abs = msf_abs(32'(speed_actual));
        err_abs = msf_abs(32'(speed_actual) - 32'(speed_instr));
        trq_abs = msf_abs(32'(torque_actual));
        dev_abs = msf_abs(pos_deviation);
    end

    // release level saturates at zero when hysteresis exceeds threshold
    assign trq_low = (st.trq_thr > st.trq_hyst) ? st.trq_thr - st.trq_hyst : 16'h0000;

    // positioning gate: value 0 needs only the deviation, 1 and 2 also an idle
    // filtered instruction, 3 additionally the continuous positioning check
    always_comb begin
        cond_ok = 1'b0;
        if (position_mode) begin
            unique case (st.cond_sel)
                COND_DEV_ONLY: cond_ok = 1'b1;
                2'h1, 2'h2:    cond_ok = pos_instr_idle;
                COND_HOLD:     cond_ok = pos_instr_idle & pos_continuous_ok;
            endcase
        end
    end

    assign use_hold = (st.cond_sel == COND_HOLD);
    assign done_raw = cond_ok & (dev_abs <= {16'h0000, st.done_thr});
    assign near_raw = cond_ok & (dev_abs <= {16'h0000, st.near_pos});

    // hold timers only see the condition in mode 3 so other modes stay immediate
    assign hold_done.cond    = done_raw & use_hold;
    assign hold_done.hold_ms = st.hold_ms;
    assign hold_near.cond    = near_raw & use_hold;
    assign hold_near.hold_ms = st.hold_ms;

    msf_hold_timer #(.MS_LEN(MS_LEN)) u_hold_done (
        .ref_clk (ref_clk),
        .rst     (rst),
        .hif     (hold_done)
    );

    msf_hold_timer #(.MS_LEN(MS_LEN)) u_hold_near (
        .ref_clk (ref_clk),
        .rst     (rst),
        .hif     (hold_near)
    );

    // a countdown left over from mode 3 is ignored once another mode is chosen
    assign done_sel = use_hold ? hold_done.held : done_raw;
    assign near_sel = use_hold ? hold_near.held : near_raw;

    // address hits a mapped register
    assign hit_sel = (reg_addr <= REG_IRQ_MASK);

    // next state: flags, register writes, interrupt status and read data
    always_comb begin
        next_st = st;
        // status flags
        next_st.flags[FLG_POS_DONE] = done_sel;
        next_st.flags[FLG_POS_NEAR] = near_sel;
        next_st.flags[FLG_ROTATE]   = spd_abs >= {16'h0000, st.rot_thr};
        next_st.flags[FLG_CONSIST]  = err_abs <= {16'h0000, st.match_thr};
        next_st.flags[FLG_APPROACH] = spd_abs >= {16'h0000, st.near_thr};
        next_st.flags[FLG_ZERO]     = spd_abs <  {16'h0000, st.zero_thr};
        // torque flag: sets at threshold, holds until below release level
        if (trq_abs >= {16'h0000, st.trq_thr}) begin
            next_st.flags[FLG_TORQUE] = 1'b1;
        end else if (trq_abs < {16'h0000, trq_low}) begin
            next_st.flags[FLG_TORQUE] = 1'b0;
        end
        // register writes; values are stored as written, range is software's job
        if (reg_wr) begin
            unique case (reg_addr)
                REG_COND_SEL:  next_st.cond_sel  = reg_wdata[1:0];
                REG_DONE_THR:  next_st.done_thr  = reg_wdata;
                REG_NEAR_POS:  next_st.near_pos  = reg_wdata;
                REG_HOLD_TIME: next_st.hold_ms   = reg_wdata;
                REG_ROT_THR:   next_st.rot_thr   = reg_wdata;
                REG_MATCH_THR: next_st.match_thr = reg_wdata;
                REG_NEAR_THR:  next_st.near_thr  = reg_wdata;
                REG_ZERO_THR:  next_st.zero_thr  = reg_wdata;
                REG_TRQ_THR:   next_st.trq_thr   = reg_wdata;
                REG_TRQ_HYST:  next_st.trq_hyst  = reg_wdata;
                REG_IRQ_MASK:  next_st.irq_mask  = reg_wdata[NUM_FLAGS-1:0];
                default: ;  // read-only and unmapped writes are dropped
            endcase
        end
        // sticky events on each rising flag; a set in the clear cycle wins
        next_st.irq_stat = st.irq_stat;
        if (reg_wr && reg_addr == REG_IRQ_STAT) begin
            next_st.irq_stat = st.irq_stat & ~reg_wdata[NUM_FLAGS-1:0];
        end
        next_st.irq_stat = next_st.irq_stat | (next_st.flags & ~st.flags);
        next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);
        // read data stands only in the cycle after the strobe
        next_st.rdata = 16'h0000;
        if (reg_rd && hit_sel) begin
            unique case (reg_addr)
                REG_COND_SEL:  next_st.rdata = {14'h0000, st.cond_sel};
                REG_DONE_THR:  next_st.rdata = st.done_thr;
                REG_NEAR_POS:  next_st.rdata = st.near_pos;
                REG_HOLD_TIME: next_st.rdata = st.hold_ms;
                REG_ROT_THR:   next_st.rdata = st.rot_thr;
                REG_MATCH_THR: next_st.rdata = st.match_thr;
                REG_NEAR_THR:  next_st.rdata = st.near_thr;
                REG_ZERO_THR:  next_st.rdata = st.zero_thr;
                REG_TRQ_THR:   next_st.rdata = st.trq_thr;
                REG_TRQ_HYST:  next_st.rdata = st.trq_hyst;
                REG_FLAGS:     next_st.rdata = {9'h000, st.flags};
                REG_IRQ_STAT:  next_st.rdata = {9'h000, st.irq_stat};
                REG_IRQ_MASK:  next_st.rdata = {9'h000, st.irq_mask};
                default:       next_st.rdata = 16'h0000;
            endcase
        end
    end

    // state register with documented reset values
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st           <= '0;
            st.cond_sel  <= RST_COND_SEL;
            st.done_thr  <= RST_DONE_THR;
            st.near_pos  <= RST_NEAR_POS;
            st.hold_ms   <= RST_HOLD_TIME;
            st.rot_thr   <= RST_ROT_THR;
            st.match_thr <= RST_MATCH_THR;
            st.near_thr  <= RST_NEAR_THR;
            st.zero_thr  <= RST_ZERO_THR;
            st.trq_thr   <= RST_TRQ_THR;
            st.trq_hyst  <= RST_TRQ_HYST;
            st.irq_mask  <= RST_IRQ_MASK;
        end else begin
            st <= next_st;
        end
    end

    // every output straight from the state register
    assign reg_rdata                 = st.rdata;
    assign positioning_complete_flag = st.flags[FLG_POS_DONE];
    assign positioning_approach_flag = st.flags[FLG_POS_NEAR];
    assign motor_rotating_flag       = st.flags[FLG_ROTATE];
    assign speed_consistent_flag     = st.flags[FLG_CONSIST];
    assign speed_approach_flag       = st.flags[FLG_APPROACH];
    assign zero_speed_flag           = st.flags[FLG_ZERO];
    assign torque_arrived_flag       = st.flags[FLG_TORQUE];
    assign irq                       = st.irq;

    // checks on the flag relations, all on ref_clk
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    chk_pos_done_mode0: assert property (
        (position_mode && st.cond_sel == COND_DEV_ONLY && dev_abs <= {16'h0000, st.done_thr})
        |=> positioning_complete_flag)
        else $error("completion flag missing with deviation inside threshold");

    chk_pos_near_out: assert property (
        (!position_mode && st.cond_sel != COND_HOLD) |=> !positioning_approach_flag)
        else $error("approach flag set outside position mode");

    chk_hold_keeps_flag: assert property (
        (use_hold && $fell(done_raw) && st.hold_ms != 16'h0000 && $stable(st.cond_sel))
        |=> positioning_complete_flag [*2])
        else $error("completion flag not held after positioning in mode 3");

    chk_rotate_level: assert property (
        $changed(motor_rotating_flag)
        |-> motor_rotating_flag == $past(spd_abs >= {16'h0000, st.rot_thr}))
        else $error("rotating flag disagrees with speed and threshold");

    chk_consist_level: assert property (
        (err_abs > {16'h0000, st.match_thr} && !reg_wr) |=> !speed_consistent_flag)
        else $error("consistent flag set with speed error above threshold");

    chk_approach_level: assert property (
        (spd_abs >= {16'h0000, st.near_thr}) |=> speed_approach_flag)
        else $error("approach flag missing at or above threshold");

    chk_zero_speed: assert property (
        zero_speed_flag |-> $past(spd_abs) < {16'h0000, $past(st.zero_thr)})
        else $error("zero speed flag with speed at or above threshold");

    chk_torque_hyst: assert property (
        (torque_arrived_flag && trq_abs >= {16'h0000, trq_low}) |=> torque_arrived_flag)
        else $error("torque flag released inside hysteresis band");

    chk_torque_set: assert property (
        (trq_abs >= {16'h0000, st.trq_thr}) ##1 (trq_abs >= {16'h0000, st.trq_thr})
        |-> torque_arrived_flag)
        else $error("torque flag missing at threshold");

    chk_irq_event: assert property (
        ($rose(speed_approach_flag) && st.irq_mask[FLG_APPROACH]) |-> irq)
        else $error("unmasked event did not raise the interrupt");

endmodule : msf_flags

// ===== verif/msf_ctrl_model.sv
/*
 * msf_ctrl_model: the motion controller that reads the drive's status flags.
 * assumes the flags come as one 7-bit bus in the drive's flag bit order.
 */
module msf_ctrl_model (
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire logic [6:0]  status,
    output logic      [15:0] rise_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic last_rot;  // rotating flag seen at the previous edge

    // the controller polls every edge and counts motion starts
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            last_rot   <= 1'b0;
            rise_count <= 16'h0000;
        end else begin
            last_rot <= status[2];
            if (status[2] && !last_rot) begin  // only starts, not levels
                rise_count <= rise_count + 16'h0001;
            end
        end
    end
endmodule : msf_ctrl_model

// ===== verif/tb_motion_status_flag_comparators.sv
/*
 * tb_motion_status_flag_comparators: drives the flag block against a model of thresholds.
 * assumes a 20 MHz clock and a short millisecond (MS_LEN 4) to keep hold runs brief.
 */
module tb_motion_status_flag_comparators;
    timeunit 1ns;
    timeprecision 1ps;
    import msf_pkg::*;
    localparam int unsigned MSL = 4;  // cycles per millisecond in this run
    logic               ref_clk, rst, reg_wr, reg_rd, irq;
    logic [3:0]         reg_addr;
    logic [15:0]        reg_wdata, reg_rdata, rises;
    logic signed [15:0] speed_actual, speed_instr, torque_actual;
    logic signed [31:0] pos_deviation;
    logic               position_mode, pos_instr_idle, pos_continuous_ok;
    wire  [6:0]         flags;  // flag bus in register bit order
    int                 n_fail, samples_checked, cycles, thr[16], rot_rises, cs, r;
    bit                 trq_m, rot_m;  // model state: torque hysteresis, last rotating
    logic [31:0]        lfsr_q;

    msf_flags #(.MS_LEN(MSL)) DUT (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .speed_actual(speed_actual), .speed_instr(speed_instr), .torque_actual(torque_actual),
        .position_mode(position_mode), .pos_deviation(pos_deviation),
        .pos_instr_idle(pos_instr_idle), .pos_continuous_ok(pos_continuous_ok),
        .positioning_complete_flag(flags[0]), .positioning_approach_flag(flags[1]),
        .motor_rotating_flag(flags[2]), .speed_consistent_flag(flags[3]),
        .speed_approach_flag(flags[4]), .zero_speed_flag(flags[5]),
        .torque_arrived_flag(flags[6]), .irq(irq));
    msf_ctrl_model ctrl (.ref_clk(ref_clk), .rst(rst), .status(flags), .rise_count(rises));

    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // galois shift register, fixed start value
    function automatic int rnd(input int m);
        lfsr_q = {lfsr_q[30:0], 1'b0} ^ (lfsr_q[31] ? 32'h04c11db7 : 32'h0);
        return int'(lfsr_q[15:0]) % m;
    endfunction : rnd

    function automatic int iabs(input int v);
        return (v < 0) ? -v : v;
    endfunction : iabs

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin  // four-state compare, an unknown matches only an unknown in the same bit
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input int idx, input int val);
        @(posedge ref_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= 4'(idx);
        reg_wdata <= 16'(val);
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        if (idx < 10) thr[idx] = val;  // mirror threshold in the model
    endtask : wr

    task automatic rd(input int idx, input int exp);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= 4'(idx);
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 check("reg_rdata", 32'(reg_rdata), 32'(exp));
    endtask : rd

    // one speed and torque sample, compared after the registering edge
    task automatic step(input int spd, input int ins, input int trq);
        int lo;
        @(posedge ref_clk);
        speed_actual  <= 16'(spd);
        speed_instr   <= 16'(ins);
        torque_actual <= 16'(trq);
        @(posedge ref_clk);
        @(posedge ref_clk);
        #1 lo = (thr[8] > thr[9]) ? thr[8] - thr[9] : 0;
        if (iabs(trq) >= thr[8]) trq_m = 1'b1;
        else if (iabs(trq) < lo) trq_m = 1'b0;
        if (iabs(spd) >= thr[4] && !rot_m) rot_rises++;
        rot_m = iabs(spd) >= thr[4];
        check("rotating", 32'(flags[2]), 32'(rot_m));
        check("consistent", 32'(flags[3]), 32'(iabs(spd - ins) <= thr[5]));
        check("approach", 32'(flags[4]), 32'(iabs(spd) >= thr[6]));
        check("zero", 32'(flags[5]), 32'(iabs(spd) < thr[7]));
        check("torque", 32'(flags[6]), 32'(trq_m));
    endtask : step

    // one deviation sample in any condition select, 0 to 3
    task automatic pstep(input int dev, input bit idle);
        bit ok;
        @(posedge ref_clk);
        pos_deviation  <= 32'(dev);
        pos_instr_idle <= idle;
        @(posedge ref_clk);
        @(posedge ref_clk);
        #1 ok = (cs == 0) || (idle && (cs < 3 || pos_continuous_ok));
        check("pos_done", 32'(flags[0]), 32'(ok && iabs(dev) <= thr[1]));
        check("pos_near", 32'(flags[1]), 32'(ok && iabs(dev) <= thr[2]));
    endtask : pstep

    task automatic wrap_up;
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : wrap_up

    // hang guard
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles > 20000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, position_mode} = '0;
        {speed_actual, speed_instr, torque_actual, pos_deviation} = '0;
        {pos_instr_idle, pos_continuous_ok} = '0;
        lfsr_q = 32'h3eca;
        thr = '{0, 800, 5000, 100, 20, 10, 100, 10, 100, 10, 0, 0, 0, 0, 0, 0};
        rst = 1'b1;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        // reset values, then refused places
        for (int i = 0; i < 10; i++) rd(i, thr[i]);
        rd(12, 0);
        rd(13, 0);
        wr(10, 16'h00ff);
        rd(10, 16'h0028);  // consistent and zero at speed 0
        $display("test registers done");
        // sticky status, mask and write-one-to-clear
        wr(12, 16'h0030);
        #1 check("irq_masked_on", 32'(irq), 32'h1);
        wr(11, 16'h007f);
        #1 check("irq_cleared", 32'(irq), 32'h0);
        step(500, 0, 0);
        step(0, 0, 0);
        rd(11, 16'h003c);
        check("irq_raised", 32'(irq), 32'h1);
        wr(12, 16'h0000);
        #1 check("irq_mask_off", 32'(irq), 32'h0);
        $display("test interrupt done");
        // thresholds at their edges and torque hysteresis
        for (int t = 0; t < 6; t++) step(19 + t * 40 - 2 * (t % 2), 12, 0);
        step(-20, -9, 100);
        step(-9, 1, 95);
        step(100, 110, 90);
        step(99, 89, 89);
        step(0, 0, -100);
        for (int k = 0; k < 40; k++) begin
            if (k % 10 == 0) wr(4 + k / 10, rnd(120));
            r = rnd(1200) - 600;
            step(r, r + rnd(31) - 15, rnd(160) - 20);
        end
        check("controller_rises", 32'(rises), 32'(rot_rises));
        $display("test speed torque done");
        // positioning in conditions 0 to 2, boundaries inclusive
        wr(1, 800);
        position_mode <= 1'b1;
        for (int c = 0; c < 3; c++) begin
            wr(0, c);
            cs = c;
            pstep(800, 0);
            pstep(-801, 1);
            pstep(5000, 1);
            pstep(5001, 0);
        end
        // condition 3: flags held hold_ms milliseconds after positioning ends
        wr(0, 3);
        cs = 3;
        wr(3, 2);
        pstep(0, 1);  // continuous check still low, so no flags yet
        @(posedge ref_clk);
        pos_continuous_ok <= 1'b1;
        repeat (3) @(posedge ref_clk);
        pos_continuous_ok <= 1'b0;
        repeat (4) @(posedge ref_clk);
        #1 check("hold_mid", 32'(flags[1:0]), 32'h3);
        repeat (2 * MSL - 4) @(posedge ref_clk);
        #1 check("hold_last", 32'(flags[1:0]), 32'h3);
        @(posedge ref_clk);
        #1 check("hold_end", 32'(flags[1:0]), 32'h0);
        wr(3, 0);
        pos_continuous_ok <= 1'b1;
        repeat (3) @(posedge ref_clk);
        pos_continuous_ok <= 1'b0;
        repeat (1) @(posedge ref_clk);
        #1 check("hold_zero", 32'(flags[1:0]), 32'h0);
        $display("test positioning done");
        wrap_up();
    end
endmodule : tb_motion_status_flag_comparators
